// >>> aca_pkg.sv
// Constants, state and operation types for the add-carry and logic ALU
package aca_pkg;

   // ----------------------------------------
   // Opcode fields
   // ----------------------------------------
   localparam logic [5:0] ACA_OPC_ADDC = 6'h08;
   localparam logic [5:0] ACA_OPC_ANDF = 6'h05;
   localparam logic [7:0] ACA_OPC_ANDL = 8'h0b;
   localparam int ACA_OPC6_LSB = 10;
   localparam int ACA_OPC8_LSB = 8;
   localparam int ACA_DEST_BIT = 9;
   localparam int ACA_BANK_BIT = 8;

   // ----------------------------------------
   // Addressing
   // ----------------------------------------
   localparam logic [7:0] ACA_INDEXED_MAX = 8'h5f;
   localparam logic [3:0] ACA_ACCESS_LO_PAGE = 4'h0;
   localparam logic [3:0] ACA_ACCESS_HI_PAGE = 4'hf;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] ACA_W_RST = 8'h00;
   localparam logic [11:0] ACA_ADDR_RST = 12'h000;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_Q1 = 3'b001,
      ST_Q2 = 3'b010,
      ST_Q3 = 3'b011,
      ST_Q4 = 3'b100
   } aca_state_t;

   typedef enum logic [1:0] {
      OP_NONE = 2'b00,
      OP_ADDC = 2'b01,
      OP_ANDL = 2'b10,
      OP_ANDF = 2'b11
   } aca_op_t;

   // Opcode word to operation
   function automatic aca_op_t aca_decode(input logic [15:0] word);
      aca_op_t op;
      op = OP_NONE;
      if (word[15:ACA_OPC6_LSB] == ACA_OPC_ADDC) begin
         op = OP_ADDC;
      end else if (word[15:ACA_OPC6_LSB] == ACA_OPC_ANDF) begin
         op = OP_ANDF;
      end else if (word[15:ACA_OPC8_LSB] == ACA_OPC_ANDL) begin
         op = OP_ANDL;
      end
      return op;
   endfunction

endpackage

// >>> aca_alu.sv
// Combinational arithmetic and logic unit with flag results
`timescale 1ns/10ps
module aca_alu
   import aca_pkg::*;
(
   input wire aca_op_t op_in,
   input wire logic [7:0] w_in,
   input wire logic [7:0] opnd_in,
   input wire logic carry_in,
   output logic [7:0] res_out,
   output logic neg_out,
   output logic wrap_out,
   output logic carry_out,
   output logic nib_out,
   output logic zero_out
);

   logic [8:0] sum9;
   logic [4:0] nib5;

   always_comb begin
      sum9 = {1'b0, w_in} + {1'b0, opnd_in} + {8'h00, carry_in};
      nib5 = {1'b0, w_in[3:0]} + {1'b0, opnd_in[3:0]} + {4'h0, carry_in};
      if (op_in == OP_ADDC) begin
         res_out = sum9[7:0];
      end else begin
         res_out = w_in & opnd_in;
      end
      neg_out = res_out[7];
      zero_out = (res_out == 8'h00);
      carry_out = sum9[8];
      nib_out = nib5[4];
      wrap_out = (w_in[7] == opnd_in[7]) && (sum9[7] != w_in[7]);
   end

endmodule

// >>> aca_core.sv
// Execution datapath for add-with-carry, AND-literal and AND-file operations
// Functional notes
// - Add-carry sums W, file, carry; all five flags
// - Destination bit zero writes W, one writes file
// - Bank bit zero access bank, one bank pointer
// - Extended set, bank zero, f<=95: indexed offset
// - AND-literal into W, only negative and zero
// - AND-literal opcode upper byte 00001011
// - AND-file routed by destination, negative, zero only
`timescale 1ns/10ps
module aca_core
   import aca_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   input wire logic instr_valid_in,
   input wire logic [15:0] instr_in,
   input wire logic ext_set_en_in,
   input wire logic [3:0] bank_select_pointer_in,
   input wire logic [11:0] index_base_in,
   input wire logic [7:0] file_rd_data_in,
   output logic ready_out,
   output logic done_out,
   output logic illegal_out,
   output logic [11:0] file_addr_out,
   output logic file_rd_en_out,
   output logic file_wr_en_out,
   output logic [7:0] file_wr_data_out,
   output logic [7:0] w_reg_out,
   output logic neg_flag_out,
   output logic twos_complement_wrap_flag_out,
   output logic carry_flag_out,
   output logic nibble_carry_flag_out,
   output logic zero_flag_out
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   aca_state_t state, next_state;
   aca_op_t op, next_op;
   logic [15:0] instr, next_instr;
   logic dest_file, next_dest_file;
   logic [7:0] operand, next_operand;
   logic next_ready, next_done, next_illegal;
   logic [11:0] next_file_addr;
   logic next_file_rd_en, next_file_wr_en;
   logic [7:0] next_file_wr_data, next_w;
   logic next_neg, next_wrap, next_carry, next_nib, next_zero;

   logic [7:0] alu_res;
   logic alu_neg, alu_wrap, alu_carry, alu_nib, alu_zero;

   // File address from the file field, bank bit and mode
   function automatic logic [11:0] form_addr(input logic [15:0] word, input logic ext,
                                             input logic [3:0] bsp, input logic [11:0] base);
      logic [7:0] fx;
      logic [11:0] a;
      fx = word[7:0];
      if (word[ACA_BANK_BIT]) begin
         a = {bsp, fx};
      end else if (fx <= ACA_INDEXED_MAX) begin
         a = ext ? (base + {4'h0, fx}) : {ACA_ACCESS_LO_PAGE, fx};
      end else begin
         a = {ACA_ACCESS_HI_PAGE, fx};
      end
      return a;
   endfunction

   aca_alu u_alu (
      .op_in(op),
      .w_in(w_reg_out),
      .opnd_in(operand),
      .carry_in(carry_flag_out),
      .res_out(alu_res),
      .neg_out(alu_neg),
      .wrap_out(alu_wrap),
      .carry_out(alu_carry),
      .nib_out(alu_nib),
      .zero_out(alu_zero)
   );

   // ----------------------------------------
   // Quarter-phase sequencer and datapath
   // ----------------------------------------
   always_comb begin
      next_state = state;
      next_op = op;
      next_instr = instr;
      next_dest_file = dest_file;
      next_operand = operand;
      next_done = 1'b0;
      next_illegal = 1'b0;
      next_file_addr = file_addr_out;
      next_file_rd_en = 1'b0;
      next_file_wr_en = 1'b0;
      next_file_wr_data = file_wr_data_out;
      next_w = w_reg_out;
      next_neg = neg_flag_out;
      next_wrap = twos_complement_wrap_flag_out;
      next_carry = carry_flag_out;
      next_nib = nibble_carry_flag_out;
      next_zero = zero_flag_out;
      case (state)
         ST_IDLE, ST_Q4: begin
            next_state = ST_IDLE;
            if (instr_valid_in) begin
               next_instr = instr_in;
               next_state = ST_Q1;
            end
         end
         ST_Q1: begin
            next_op = aca_decode(instr);
            next_dest_file = instr[ACA_DEST_BIT] && (next_op != OP_ANDL);
            next_file_addr = form_addr(instr, ext_set_en_in, bank_select_pointer_in,
                                       index_base_in);
            next_file_rd_en = (next_op == OP_ADDC) || (next_op == OP_ANDF);
            if (next_op == OP_NONE) begin
               next_illegal = 1'b1;
               next_state = ST_IDLE;
            end else begin
               next_state = ST_Q2;
            end
         end
         ST_Q2: begin
            next_operand = (op == OP_ANDL) ? instr[7:0] : file_rd_data_in;
            next_state = ST_Q3;
         end
         ST_Q3: begin
            next_neg = alu_neg;
            next_zero = alu_zero;
            if (op == OP_ADDC) begin
               next_wrap = alu_wrap;
               next_carry = alu_carry;
               next_nib = alu_nib;
            end
            if (dest_file) begin
               next_file_wr_en = 1'b1;
               next_file_wr_data = alu_res;
            end else begin
               next_w = alu_res;
            end
            next_done = 1'b1;
            next_state = ST_Q4;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      next_ready = (next_state == ST_IDLE) || (next_state == ST_Q4);
   end

   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state <= ST_IDLE;
         op <= OP_NONE;
         instr <= 16'h0000;
         dest_file <= 1'b0;
         operand <= 8'h00;
         ready_out <= 1'b1;
         done_out <= 1'b0;
         illegal_out <= 1'b0;
         file_addr_out <= ACA_ADDR_RST;
         file_rd_en_out <= 1'b0;
         file_wr_en_out <= 1'b0;
         file_wr_data_out <= 8'h00;
         w_reg_out <= ACA_W_RST;
         neg_flag_out <= 1'b0;
         twos_complement_wrap_flag_out <= 1'b0;
         carry_flag_out <= 1'b0;
         nibble_carry_flag_out <= 1'b0;
         zero_flag_out <= 1'b0;
      end else begin
         state <= next_state;
         op <= next_op;
         instr <= next_instr;
         dest_file <= next_dest_file;
         operand <= next_operand;
         ready_out <= next_ready;
         done_out <= next_done;
         illegal_out <= next_illegal;
         file_addr_out <= next_file_addr;
         file_rd_en_out <= next_file_rd_en;
         file_wr_en_out <= next_file_wr_en;
         file_wr_data_out <= next_file_wr_data;
         w_reg_out <= next_w;
         neg_flag_out <= next_neg;
         twos_complement_wrap_flag_out <= next_wrap;
         carry_flag_out <= next_carry;
         nibble_carry_flag_out <= next_nib;
         zero_flag_out <= next_zero;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!nrst_in);

   logic [8:0] chk_sum;
   assign chk_sum = {1'b0, w_reg_out} + {1'b0, operand} + {8'h00, carry_flag_out};

   sequence s_decoded;
      state == ST_Q1 && aca_decode(instr) != OP_NONE;
   endsequence
   sequence s_phases;
      state == ST_Q2 ##1 state == ST_Q3 ##1 state == ST_Q4 && done_out;
   endsequence

   a_quarter_phases: assert property (s_decoded |=> s_phases)
      else $error("Operation did not pass through the four phases");

   a_addc_sum: assert property (state == ST_Q3 && op == OP_ADDC |=>
      carry_flag_out == $past(chk_sum[8]) && zero_flag_out == ($past(chk_sum[7:0]) == 8'h00))
      else $error("Add-carry sum or flags wrong");

   a_dest_w: assert property (state == ST_Q3 && !dest_file |=>
      !file_wr_en_out && w_reg_out == $past(alu_res))
      else $error("Result not written to W");

   a_dest_file: assert property (state == ST_Q3 && dest_file |=>
      file_wr_en_out && file_wr_data_out == $past(alu_res) && $stable(w_reg_out))
      else $error("Result not written to file location");

   a_bank_ptr: assert property (state == ST_Q1 && instr[ACA_BANK_BIT] |=>
      file_addr_out == {$past(bank_select_pointer_in), $past(instr[7:0])})
      else $error("Bank pointer address wrong");

   a_indexed_mode: assert property (state == ST_Q1 && !instr[ACA_BANK_BIT] && ext_set_en_in
      && instr[7:0] <= ACA_INDEXED_MAX |=>
      file_addr_out == $past(index_base_in) + {4'h0, $past(instr[7:0])})
      else $error("Indexed offset address wrong");

   a_andl_result: assert property (state == ST_Q3 && op == OP_ANDL |=>
      w_reg_out == ($past(w_reg_out) & $past(instr[7:0])) && $stable(carry_flag_out)
      && $stable(twos_complement_wrap_flag_out))
      else $error("AND-literal result or flags wrong");

   a_andl_decode: assert property (state == ST_Q1 && instr[15:8] == ACA_OPC_ANDL |=>
      op == OP_ANDL && !file_rd_en_out && state == ST_Q2)
      else $error("AND-literal decode wrong");

   a_andf_flags: assert property (state == ST_Q3 && op == OP_ANDF |=>
      $stable(carry_flag_out) && $stable(nibble_carry_flag_out)
      && neg_flag_out == $past(alu_res[7]))
      else $error("AND-file flags wrong");

   a_addc_decode: assert property (state == ST_Q1 && instr[15:10] == ACA_OPC_ADDC |=>
      op == OP_ADDC && file_rd_en_out)
      else $error("Add-carry decode wrong");

endmodule

// >>> aca_mem_model.sv
// Behavioural data memory facing the datapath
`timescale 1ns/10ps
module aca_mem_model (
   input wire logic ref_clk_in,
   input wire logic [11:0] addr_in,
   input wire logic rd_en_in,
   input wire logic wr_en_in,
   input wire logic [7:0] wr_data_in,
   output logic [7:0] rd_data_out
);
   logic [7:0] mem [0:4095];
   logic [7:0] last = 8'h00;
   initial begin
      for (int i = 0; i < 4096; i++) begin
         mem[i] = i[7:0] ^ {i[11:8], i[11:8]};
      end
   end
   // Released bus shows inverse of last value
   assign rd_data_out = rd_en_in ? mem[addr_in] : ~last;
   always @(posedge ref_clk_in) begin
      if (rd_en_in) begin
         last <= mem[addr_in];
      end
      if (wr_en_in) begin
         mem[addr_in] <= wr_data_in;
      end
   end
endmodule

// >>> tb_aca_core.sv
// Self-checking bench for the add-carry and logic datapath
`timescale 1ns/10ps
module tb_aca_core;
   import aca_pkg::*;
   logic ref_clk_in, nrst_in, instr_valid_in, ext_set_en_in;
   logic [15:0] instr_in;
   logic [3:0] bsp;
   logic [11:0] base, file_addr_out;
   logic [7:0] rd_data, file_wr_data_out, w_reg_out;
   logic ready_out, done_out, illegal_out, file_rd_en_out, file_wr_en_out;
   logic neg, wrap, cy, nib, zero;
   int fails = 0;
   int check_count = 0;
   int cycles = 0;
   logic [31:0] rnd = 32'h2ff5;
   logic [7:0] ew = 8'h00;
   logic ec = 1'b0, en = 1'b0, ev = 1'b0, ed = 1'b0, ez = 1'b0;
   logic [15:0] cw [7] = '{16'h214d, 16'h205f, 16'h2060, 16'h1410, 16'h1610, 16'h0b5f,
      16'hffff};

   aca_core aca_core_inst (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
      .instr_valid_in(instr_valid_in), .instr_in(instr_in), .ext_set_en_in(ext_set_en_in),
      .bank_select_pointer_in(bsp), .index_base_in(base), .file_rd_data_in(rd_data),
      .ready_out(ready_out), .done_out(done_out), .illegal_out(illegal_out),
      .file_addr_out(file_addr_out), .file_rd_en_out(file_rd_en_out),
      .file_wr_en_out(file_wr_en_out), .file_wr_data_out(file_wr_data_out),
      .w_reg_out(w_reg_out), .neg_flag_out(neg), .twos_complement_wrap_flag_out(wrap),
      .carry_flag_out(cy), .nibble_carry_flag_out(nib), .zero_flag_out(zero));

   aca_mem_model mem_inst (.ref_clk_in(ref_clk_in), .addr_in(file_addr_out),
      .rd_en_in(file_rd_en_out), .wr_en_in(file_wr_en_out),
      .wr_data_in(file_wr_data_out), .rd_data_out(rd_data));

   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   function automatic logic [11:0] exp_addr(input logic [7:0] f, input logic a, input logic x);
      if (a) return {bsp, f};
      if (x && f <= 8'h5f) return base + {4'h0, f};
      return {(f <= 8'h5f) ? 4'h0 : 4'hf, f};
   endfunction

   // One operation, driven at falling edges, checked on its answer
   task automatic run_op(input logic [15:0] word);
      logic [11:0] ad;
      logic [8:0] s;
      logic [4:0] s4;
      logic [7:0] opnd, r;
      int n;
      logic rd_seen, add, andl, fop, dst, legal;
      add = word[15:ACA_OPC6_LSB] === ACA_OPC_ADDC;
      andl = word[15:ACA_OPC8_LSB] === ACA_OPC_ANDL;
      fop = add || word[15:ACA_OPC6_LSB] === ACA_OPC_ANDF;
      legal = fop || andl;
      dst = fop && word[ACA_DEST_BIT];
      ad = exp_addr(word[7:0], word[ACA_BANK_BIT], ext_set_en_in);
      instr_in = word;
      instr_valid_in = 1'b1;
      @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      instr_valid_in = 1'b0;
      opnd = andl ? word[7:0] : mem_inst.mem[ad];
      n = 1;
      rd_seen = 1'b0;
      while (!(done_out === 1'b1 || illegal_out === 1'b1) && n < 8) begin
         rd_seen |= file_rd_en_out === 1'b1;
         @(negedge ref_clk_in);
         n++;
      end
      s = {1'b0, ew} + {1'b0, opnd} + {8'h00, ec};
      s4 = {1'b0, ew[3:0]} + {1'b0, opnd[3:0]} + {4'h0, ec};
      r = add ? s[7:0] : (ew & opnd);
      check(12'(illegal_out), 12'(!legal));
      check(12'(n), legal ? 12'h4 : 12'h2);
      check(12'(rd_seen), 12'(fop));
      check(12'(file_wr_en_out), 12'(dst));
      check(12'(ready_out), 12'h1);
      if (fop) check(file_addr_out, ad);
      if (dst) check(12'(file_wr_data_out), 12'(r));
      if (legal) begin
         en = r[7];
         ez = r == 8'h00;
         if (add) begin
            ev = (ew[7] == opnd[7]) && (s[7] != ew[7]);
            ec = s[8];
            ed = s4[4];
         end
         if (!dst) ew = r;
      end
      check(12'(w_reg_out), 12'(ew));
      check(12'({neg, wrap, cy, nib, zero}), 12'({en, ev, ec, ed, ez}));
   endtask

   initial begin
      ref_clk_in = 1'b0;
      forever #25 ref_clk_in = ~ref_clk_in;
   end

   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         finish_test();
      end
   end

   initial begin
      nrst_in = 1'b0;
      instr_valid_in = 1'b0;
      instr_in = 16'h0000;
      ext_set_en_in = 1'b1;
      bsp = 4'h3;
      base = 12'h800;
      repeat (8) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      nrst_in = 1'b1;
      check(12'(ready_out), 12'h1);
      check(12'(w_reg_out), 12'h0);
      foreach (cw[i]) run_op(cw[i]);
      repeat (80) begin
         rnd = lfsr(rnd);
         ext_set_en_in = rnd[4];
         bsp = rnd[11:8];
         base = rnd[31:20];
         case (rnd[1:0])
            2'd0: run_op({ACA_OPC_ADDC, rnd[25:16]});
            2'd1: run_op({ACA_OPC_ANDF, rnd[25:16]});
            2'd2: run_op({ACA_OPC_ANDL, rnd[23:16]});
            default: run_op(rnd[31:16]);
         endcase
      end
      finish_test();
   end
endmodule
